// ==== logic/mmec_top.sv ====
// multi-mode event counter: constants package and top level with avalon-mm slave
// Operation
// - count source picked from any source pin, gate pin or internal tick
// - special gate bit: zero enables special gating, one disables it
// - reload from load register, or from load or hold per configuration
// - cycle zero: count once to terminal count, then disarm itself
// - cycle one: reload at every terminal count and keep counting until disarmed
// - count type zero: plain binary over sixteen bits, maximum 65535
// - count type one: bcd, four nibbles of 0 to 9, maximum 9999
// - direction zero counts down, direction one counts up
// - toggle output inverts at every terminal count until disarmed
// - pulse output emits a pulse of chosen polarity at terminal count
// - output may be held low or released to high impedance
// - counter idles until armed, counts while armed, stops when disarmed
// - save and disarm-and-save copy the present count into the hold register
// - save alone leaves the count running undisturbed
// - load copies load register into counter; load-and-arm also arms
// - status byte returns the output level of all five counters
// - no-action command changes nothing yet status still reads
// - lower-neighbour gating counts only while that counter sits at terminal count
// - edge bit zero counts rising edges, one counts falling edges
// - status: byte pointer bit 0, outputs bits 1 to 5, comparators bits 6, 7
// - group command hits every selected counter at once, identically
`timescale 1ns/10ps

package mmec_pkg;
  localparam int          NUM_CTR       = 5;
  localparam int          NUM_LVL       = 10;    // five source pins then five gate pins
  localparam int          DATA_W        = 16;
  localparam int          MODE_W        = 18;
  localparam int          ADDR_W        = 8;
  // byte addresses of the register map
  localparam logic [7:0]  ADDR_CMD      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_CTR_LO   = 8'h10;  // counter n block at 8'h10 * (n + 1)
  localparam logic [7:0]  ADDR_CTR_HI   = 8'h5f;
  localparam logic [3:0]  OFS_MODE      = 4'h0;
  localparam logic [3:0]  OFS_LOAD      = 4'h4;
  localparam logic [3:0]  OFS_HOLD      = 4'h8;
  localparam logic [3:0]  OFS_COUNT     = 4'hc;
  // command word fields
  localparam int          CMD_ACT_LSB   = 0;
  localparam int          CMD_SEL_LSB   = 8;
  // mode word fields
  localparam int          M_SRC_LSB     = 0;     // 4 bits
  localparam int          M_GSEL_LSB    = 4;     // 3 bits
  localparam int          M_GATE_LSB    = 7;     // 2 bits
  localparam int          M_EDGE        = 9;
  localparam int          M_SPECIAL     = 10;
  localparam int          M_RELOAD      = 11;
  localparam int          M_CYCLE       = 12;
  localparam int          M_TYPE        = 13;
  localparam int          M_DIR         = 14;
  localparam int          M_OUT_LSB     = 15;    // 3 bits
  localparam logic [17:0] MODE_RESET    = 18'h00000;
  localparam logic [15:0] LOAD_RESET    = 16'h0000;
  // count sources above the pins
  localparam logic [3:0]  SRC_TICK      = 4'ha;
  // gating codes
  localparam logic [1:0]  GATE_NONE     = 2'h0;
  localparam logic [1:0]  GATE_HIGH     = 2'h1;
  localparam logic [1:0]  GATE_LOW      = 2'h2;
  localparam logic [1:0]  GATE_LOWER_TC = 2'h3;
  // output codes
  localparam logic [2:0]  OUT_LOW       = 3'h0;
  localparam logic [2:0]  OUT_PULSE_HI  = 3'h1;
  localparam logic [2:0]  OUT_PULSE_LO  = 3'h2;
  localparam logic [2:0]  OUT_TOGGLE    = 3'h3;
  localparam logic [2:0]  OUT_HIGHZ     = 3'h4;
  // end values
  localparam logic [15:0] BIN_MAX       = 16'hffff;
  localparam logic [15:0] BCD_MAX       = 16'h9999;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  // internal tick source timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          TICK_PERIOD_NS = 1000;
  localparam int          TICK_CYCLES   = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ACT_NONE        = 3'h0,
    ACT_LOAD        = 3'h1,
    ACT_ARM         = 3'h2,
    ACT_LOAD_ARM    = 3'h3,
    ACT_DISARM      = 3'h4,
    ACT_SAVE        = 3'h5,
    ACT_DISARM_SAVE = 3'h6
  } mmec_action_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ARMED = 2'b10
  } mmec_state_type;
endpackage : mmec_pkg

module mmec_top
  import mmec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  src_pin,
  input  wire logic [4:0]  gate_pin,
  output logic      [4:0]  cnt_out,
  output logic      [4:0]  cnt_out_oe
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [NUM_LVL-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic [NUM_LVL-1:0] sync1_next, sync2_next, sync3_next, filt_next;
  logic [7:0]         tick_cnt_reg, tick_cnt_next;
  logic               tick_reg, tick_next;
  logic               waitreq_reg, waitreq_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic               internal_byte_pointer_reg, internal_byte_pointer_next;
  logic [MODE_W-1:0]  mode_reg [NUM_CTR];
  logic [MODE_W-1:0]  mode_next [NUM_CTR];
  logic [DATA_W-1:0]  load_reg [NUM_CTR];
  logic [DATA_W-1:0]  load_next [NUM_CTR];

  logic               req;
  logic               take_wr;
  logic               ctr_hit;
  logic [2:0]         ctr_idx;
  logic [3:0]         ctr_ofs;
  mmec_action_type    action;
  logic [NUM_CTR-1:0] sel_mask;
  logic [NUM_CTR-1:0] do_load, do_arm, do_disarm, do_save, hold_wr;
  logic [NUM_CTR-1:0] tc_state, out_level, out_en;
  logic [DATA_W-1:0]  count_val [NUM_CTR];
  logic [DATA_W-1:0]  hold_val [NUM_CTR];
  logic [NUM_CTR:0]   lower_tc;
  logic               first_comparator_flag, second_comparator_flag;
  logic [7:0]         status_byte;

  // ****************************************************************
  // pin synchronisers: three stages, a change counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    sync1_next = {gate_pin, src_pin};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    filt_next  = (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      filt_reg  <= filt_next;
    end
  end

  // ****************************************************************
  // internal tick source: one-cycle enable every TICK_CYCLES clocks
  // ****************************************************************
  always_comb begin
    if (tick_cnt_reg == 8'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 8'h00;
      tick_next     = 1'b1;
    end else begin
      tick_cnt_next = tick_cnt_reg + 8'h01;
      tick_next     = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ****************************************************************
  // bus decode: one wait cycle, then the request is taken
  // ****************************************************************
  assign req     = avs_read | avs_write;
  assign take_wr = avs_write & ~waitreq_reg;
  assign ctr_hit = (avs_address >= ADDR_CTR_LO) && (avs_address <= ADDR_CTR_HI);
  assign ctr_idx = avs_address[6:4] - 3'h1;
  assign ctr_ofs = avs_address[3:0];

  // command decode, applied to all selected counters in the same cycle
  always_comb begin
    action    = mmec_action_type'(avs_writedata[CMD_ACT_LSB +: 3]);
    sel_mask  = avs_writedata[CMD_SEL_LSB +: NUM_CTR];
    do_load   = '0;
    do_arm    = '0;
    do_disarm = '0;
    do_save   = '0;
    hold_wr   = '0;
    if (take_wr && avs_address == ADDR_CMD) begin
      case (action)
        ACT_LOAD:        do_load = sel_mask;
        ACT_ARM:         do_arm = sel_mask;
        ACT_LOAD_ARM: begin
          do_load = sel_mask;
          do_arm  = sel_mask;
        end
        ACT_DISARM:      do_disarm = sel_mask;
        ACT_SAVE:        do_save = sel_mask;
        ACT_DISARM_SAVE: begin
          do_disarm = sel_mask;
          do_save   = sel_mask;
        end
        default: begin
          do_load = '0;
        end
      endcase
    end
    if (take_wr && ctr_hit && ctr_ofs == OFS_HOLD) begin
      hold_wr[ctr_idx] = 1'b1;
    end
  end

  // mode and load registers written by software
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      mode_next[i] = mode_reg[i];
      load_next[i] = load_reg[i];
    end
    if (take_wr && ctr_hit) begin
      if (ctr_ofs == OFS_MODE) begin
        mode_next[ctr_idx] = avs_writedata[MODE_W-1:0];
      end
      if (ctr_ofs == OFS_LOAD) begin
        load_next[ctr_idx] = avs_writedata[DATA_W-1:0];
      end
    end
  end

  // status byte and read mux
  assign first_comparator_flag        = (count_val[0] == hold_val[0]);
  assign second_comparator_flag        = (count_val[1] == hold_val[1]);
  assign status_byte = {second_comparator_flag, first_comparator_flag, out_level, internal_byte_pointer_reg};

  always_comb begin
    waitreq_next = ~(req & waitreq_reg);
    rdata_next   = rdata_reg;
    internal_byte_pointer_next    = internal_byte_pointer_reg;
    if (avs_read && !waitreq_reg && avs_address == ADDR_STATUS) begin
      internal_byte_pointer_next = ~internal_byte_pointer_reg;                               // pointer steps per status read
    end
    if (avs_read && waitreq_reg) begin
      rdata_next = 32'h00000000;
      if (avs_address == ADDR_STATUS) begin
        rdata_next[7:0] = status_byte;
      end else if (ctr_hit) begin
        case (ctr_ofs)
          OFS_MODE:  rdata_next[MODE_W-1:0] = mode_reg[ctr_idx];
          OFS_LOAD:  rdata_next[DATA_W-1:0] = load_reg[ctr_idx];
          OFS_HOLD:  rdata_next[DATA_W-1:0] = hold_val[ctr_idx];
          OFS_COUNT: rdata_next[DATA_W-1:0] = count_val[ctr_idx];
          default:   rdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h00000000;
      internal_byte_pointer_reg    <= 1'b0;
      for (int i = 0; i < NUM_CTR; i++) begin
        mode_reg[i] <= MODE_RESET;
        load_reg[i] <= LOAD_RESET;
      end
    end else begin
      waitreq_reg <= waitreq_next;
      rdata_reg   <= rdata_next;
      internal_byte_pointer_reg    <= internal_byte_pointer_next;
      for (int i = 0; i < NUM_CTR; i++) begin
        mode_reg[i] <= mode_next[i];
        load_reg[i] <= load_next[i];
      end
    end
  end

  assign avs_waitrequest = waitreq_reg;
  assign avs_readdata    = rdata_reg;

  // ****************************************************************
  // counters, chained through the lower neighbour terminal count
  // ****************************************************************
  assign lower_tc[0] = 1'b0;                               // counter one has no lower neighbour

  for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
    assign lower_tc[g+1] = tc_state[g];

    mmec_counter u_ctr (
      .clk        (clk),
      .arst_n     (arst_n),
      .mode       (mode_reg[g]),
      .load_val   (load_reg[g]),
      .levels     (filt_reg),
      .tick       (tick_reg),
      .lower_tc   (lower_tc[g]),
      .cmd_load   (do_load[g]),
      .cmd_arm    (do_arm[g]),
      .cmd_disarm (do_disarm[g]),
      .cmd_save   (do_save[g]),
      .hold_wr    (hold_wr[g]),
      .hold_wdata (avs_writedata[DATA_W-1:0]),
      .count      (count_val[g]),
      .hold       (hold_val[g]),
      .tc_state   (tc_state[g]),
      .out_level  (out_level[g]),
      .out_en     (out_en[g])
    );
  end

  assign cnt_out    = out_level;
  assign cnt_out_oe = out_en;

endmodule : mmec_top

// ==== logic/mmec_counter.sv ====
// one sixteen-bit event counter with mode decode, reload, hold and output logic
`timescale 1ns/10ps

module mmec_counter
  import mmec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [MODE_W-1:0] mode,
  input  wire logic [DATA_W-1:0] load_val,
  input  wire logic [NUM_LVL-1:0] levels,
  input  wire logic              tick,
  input  wire logic              lower_tc,
  input  wire logic              cmd_load,
  input  wire logic              cmd_arm,
  input  wire logic              cmd_disarm,
  input  wire logic              cmd_save,
  input  wire logic              hold_wr,
  input  wire logic [DATA_W-1:0] hold_wdata,
  output logic      [DATA_W-1:0] count,
  output logic      [DATA_W-1:0] hold,
  output logic                   tc_state,
  output logic                   out_level,
  output logic                   out_en
);

  // bcd step by one, rippling the carry or borrow through the nibbles
  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic        carry;
    r     = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        if (up) begin
          if (v[4*i +: 4] >= 4'h9) begin
            r[4*i +: 4] = 4'h0;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] + 4'h1;
            carry       = 1'b0;
          end
        end else begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            carry       = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : bcd_step

  // ****************************************************************
  // state
  // ****************************************************************
  mmec_state_type    state_reg, state_next;
  logic [DATA_W-1:0] count_reg, count_next;
  logic [DATA_W-1:0] hold_reg, hold_next;
  logic              out_reg, out_next;
  logic              oe_reg, oe_next;
  logic              prev_reg, prev_next;
  logic              alt_reg, alt_next;

  logic [3:0]        src;
  logic [2:0]        gsel;
  logic              sel_level, gate_level, gate_ok, active_edge, armed;
  logic [DATA_W-1:0] end_val, reload_val;
  logic              at_end, step, wrap;

  // ****************************************************************
  // source, gate and terminal count decode
  // ****************************************************************
  always_comb begin
    src        = mode[M_SRC_LSB +: 4];
    gsel       = mode[M_GSEL_LSB +: 3];
    armed      = (state_reg == ST_ARMED);
    sel_level  = (src < 4'(NUM_LVL)) ? levels[src] : 1'b0;
    gate_level = (gsel < 3'(NUM_CTR)) ? levels[4'(NUM_CTR) + 4'(gsel)] : 1'b0;
    if (src == SRC_TICK) begin
      active_edge = tick;
    end else if (mode[M_EDGE]) begin
      active_edge = prev_reg & ~sel_level;
    end else begin
      active_edge = ~prev_reg & sel_level;
    end
    case (mode[M_GATE_LSB +: 2])
      GATE_HIGH:     gate_ok = gate_level;
      GATE_LOW:      gate_ok = ~gate_level;
      GATE_LOWER_TC: gate_ok = lower_tc;
      default:       gate_ok = 1'b1;
    endcase
    if (!mode[M_DIR]) begin
      end_val = CNT_ZERO;
    end else begin
      end_val = mode[M_TYPE] ? BCD_MAX : BIN_MAX;
    end
    at_end = (count_reg == end_val);
    step   = armed & active_edge & gate_ok;
    wrap   = step & at_end;
    // special gating picks the register by gate level, otherwise they alternate
    if (!mode[M_RELOAD]) begin
      reload_val = load_val;
    end else if (!mode[M_SPECIAL]) begin
      reload_val = gate_level ? hold_reg : load_val;
    end else begin
      reload_val = alt_reg ? hold_reg : load_val;
    end
  end

  // ****************************************************************
  // next count, state and hold; commands override counting
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    hold_next  = hold_reg;
    alt_next   = alt_reg;
    prev_next  = sel_level;
    if (step) begin
      if (at_end) begin
        count_next = reload_val;
        alt_next   = ~alt_reg;
        if (!mode[M_CYCLE]) begin
          state_next = ST_IDLE;
        end
      end else if (mode[M_TYPE]) begin
        count_next = bcd_step(count_reg, mode[M_DIR]);
      end else if (mode[M_DIR]) begin
        count_next = count_reg + 16'h0001;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
    if (hold_wr) begin
      hold_next = hold_wdata;
    end
    if (cmd_save) begin
      hold_next = count_reg;
    end
    if (cmd_disarm) begin
      state_next = ST_IDLE;
    end
    if (cmd_load) begin
      count_next = load_val;
      alt_next   = 1'b0;
    end
    if (cmd_arm) begin
      state_next = ST_ARMED;
    end
  end

  // output pin behaviour
  always_comb begin
    out_next = out_reg;
    oe_next  = 1'b1;
    case (mode[M_OUT_LSB +: 3])
      OUT_LOW:      out_next = 1'b0;
      OUT_PULSE_HI: out_next = armed & at_end;
      OUT_PULSE_LO: out_next = ~(armed & at_end);
      OUT_TOGGLE:   out_next = out_reg ^ wrap;
      OUT_HIGHZ: begin
        out_next = 1'b0;
        oe_next  = 1'b0;
      end
      default:      out_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= CNT_ZERO;
      hold_reg  <= CNT_ZERO;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b1;
      prev_reg  <= 1'b0;
      alt_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      hold_reg  <= hold_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      prev_reg  <= prev_next;
      alt_reg   <= alt_next;
    end
  end

  assign count     = count_reg;
  assign hold      = hold_reg;
  assign tc_state  = (state_reg == ST_ARMED) & at_end;
  assign out_level = out_reg;
  assign out_en    = oe_reg;

endmodule : mmec_counter

// ==== verification/mmec_asserts.sv ====
// bus and status checks on the event counter top ports
`timescale 1ns/10ps
module mmec_asserts
  import mmec_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  cnt_out
);
  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic rd_ok;
  // read data handed over in this cycle
  assign rd_ok = avs_read && !avs_waitrequest;
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved between reads");
  a_status_outs: assert property (
    rd_ok && avs_address == ADDR_STATUS |-> avs_readdata[5:1] == $past(cnt_out))
    else $error("status output bits differ from outputs");
  a_status_top: assert property (
    rd_ok && avs_address == ADDR_STATUS |-> avs_readdata[31:8] == '0)
    else $error("status upper bits set");
  a_cmd_zero: assert property (rd_ok && avs_address == ADDR_CMD |-> avs_readdata == '0)
    else $error("command word reads nonzero");
  a_unmapped_zero: assert property (rd_ok && avs_address > ADDR_CTR_HI |-> avs_readdata == '0)
    else $error("unmapped read nonzero");
  a_count_width: assert property (
    rd_ok && avs_address >= ADDR_CTR_LO && avs_address[3:0] == OFS_COUNT
    |-> avs_readdata[31:16] == '0)
    else $error("count wider than sixteen bits");
endmodule : mmec_asserts

// ==== verification/mmec_pins_model.sv ====
// external source and gate pin driver
`timescale 1ns/10ps
module mmec_pins_model (
  input  wire logic       clk,
  output logic      [4:0] src_pin,
  output logic      [4:0] gate_pin
);
  // pins rest low
  initial begin
    src_pin  = '0;
    gate_pin = '0;
  end
  // each level held five clocks so the filter always accepts it
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      src_pin[idx] <= 1'b1;
      repeat (5) @(posedge clk);
      src_pin[idx] <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask : pulse
endmodule : mmec_pins_model

// ==== verification/tb_multi_mode_event_counter.sv ====
// self-checking testbench for the event counter group
`timescale 1ns/10ps
module tb_multi_mode_event_counter;
  import mmec_pkg::*;
  localparam int k_up = 1 << M_DIR;
  localparam int k_rec = 1 << M_CYCLE;
  localparam int k_bcd = 1 << M_TYPE;
  localparam int k_rl = (1 << M_RELOAD) | (1 << M_SPECIAL);
  logic        clk = 0;
  logic        arst_n = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [7:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic        avs_waitrequest;
  logic [4:0]  src_pin, gate_pin, cnt_out, cnt_out_oe;
  int          fail_count = 0, n_tests = 0, cyc = 0, n_st = 0;
  int          m_cnt[5], m_ld[5], m_hd[5], m_arm[5], m_alt[5], m_tog[5], m_md[5];
  // ********************
  // clock, design and pins
  // ********************
  always #50 clk = ~clk;
  always @(posedge clk) if (++cyc > 20000) begin
    fail_count++;
    test_done();
  end
  mmec_top DUT (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .src_pin, .gate_pin, .cnt_out, .cnt_out_oe);
  mmec_pins_model pins (.clk, .src_pin, .gate_pin);
  // ********************
  // tasks and model
  // ********************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic logic [7:0] ra(int i, logic [3:0] o);
    return 8'((i + 1) * 16 + o);
  endfunction : ra
  function automatic int endv(int i);
    return (m_md[i] >> M_DIR & 1) ? ((m_md[i] >> M_TYPE & 1) ? 'h9999 : 'hffff) : 0;
  endfunction : endv
  function automatic int bcd_inc(int v);
    for (int k = 0; k < 16; k += 4) begin
      if ((v >> k & 15) < 9) return v + (1 << k);
      v &= ~(15 << k);
    end
    return v;
  endfunction : bcd_inc
  // one active edge on an armed counter
  function automatic void step(int i);
    int rs = m_md[i] >> M_RELOAD & 1;
    if (m_cnt[i] == endv(i)) begin
      m_cnt[i] = (rs && m_alt[i]) ? m_hd[i] : m_ld[i];
      m_alt[i] ^= rs;
      m_tog[i] ^= 1;
      if (!(m_md[i] >> M_CYCLE & 1)) m_arm[i] = 0;
    end else if (m_md[i] >> M_DIR & 1)
      m_cnt[i] = (m_md[i] >> M_TYPE & 1) ? bcd_inc(m_cnt[i]) : m_cnt[i] + 1;
    else m_cnt[i] = m_cnt[i] - 1;
  endfunction : step
  function automatic bit exp_out(int i);
    case (m_md[i] >> M_OUT_LSB)
      OUT_PULSE_HI: return m_arm[i] && m_cnt[i] == endv(i);
      OUT_PULSE_LO: return !(m_arm[i] && m_cnt[i] == endv(i));
      OUT_TOGGLE: return m_tog[i][0];
      default: return 1'b0;
    endcase
  endfunction : exp_out
  task automatic cfg(int i, int src, int bits, int out, int ld);
    m_md[i] = src | bits | out << M_OUT_LSB;
    m_ld[i] = ld;
    bus(1, ra(i, OFS_MODE), m_md[i]);
    bus(0, ra(i, OFS_MODE), 0);
    chk("mode", q, m_md[i]);
    bus(1, ra(i, OFS_LOAD), ld);
  endtask : cfg
  task automatic cmd(mmec_action_type act, int sel);
    bus(1, ADDR_CMD, 32'(act) | sel << CMD_SEL_LSB);
    for (int i = 0; i < 5; i++) if (sel >> i & 1) begin
      if (act == ACT_SAVE || act == ACT_DISARM_SAVE) m_hd[i] = m_cnt[i];
      if (act == ACT_LOAD || act == ACT_LOAD_ARM) begin
        m_cnt[i] = m_ld[i];
        m_alt[i] = 0;
      end
      if (act == ACT_ARM || act == ACT_LOAD_ARM) m_arm[i] = 1;
      if (act == ACT_DISARM || act == ACT_DISARM_SAVE) m_arm[i] = 0;
    end
  endtask : cmd
  task automatic pulses(int p, int n);
    pins.pulse(p, n);
    repeat (6) @(posedge clk);
    // lower-neighbour gating lets an edge through only while that counter sits at its end
    repeat (n) for (int i = 0; i < 5; i++) if (m_arm[i] && (m_md[i] & 15) == p &&
        ((m_md[i] >> M_GATE_LSB & 3) != GATE_LOWER_TC ||
         i > 0 && m_arm[i-1] && m_cnt[i-1] == endv(i-1))) step(i);
  endtask : pulses
  task automatic check_all();
    logic [4:0] eo, eoe;
    for (int i = 0; i < 5; i++) begin
      eo[i] = exp_out(i);
      eoe[i] = (m_md[i] >> M_OUT_LSB) != OUT_HIGHZ;
      bus(0, ra(i, OFS_COUNT), 0);
      chk("count", q, m_cnt[i]);
      bus(0, ra(i, OFS_HOLD), 0);
      chk("hold", q, m_hd[i]);
    end
    bus(0, ADDR_STATUS, 0);
    chk("status", q, {24'h0, m_cnt[1] == m_hd[1], m_cnt[0] == m_hd[0], eo, n_st[0]});
    n_st++;
    chk("out", 32'(cnt_out & eoe), 32'(eo & eoe));
    chk("oe", 32'(cnt_out_oe), 32'(eoe));
  endtask : check_all
  // ********************
  // scenarios
  // ********************
  initial begin
    void'($urandom(29365));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1, 8'h60, $urandom);
    bus(0, 8'h60, 0);
    chk("unmapped", q, 0);
    bus(0, ADDR_CMD, 0);
    check_all();
    cfg(0, 2, k_up | k_rec, OUT_PULSE_HI, $urandom_range(65000));
    cfg(4, 2, k_up | k_rec, OUT_TOGGLE, 'hfffe);
    cmd(ACT_LOAD_ARM, 'h11);
    pulses(2, 3);
    check_all();
    cmd(ACT_SAVE, 1);
    pulses(2, 2);
    check_all();
    cmd(ACT_DISARM_SAVE, 'h11);
    pulses(2, 2);
    check_all();
    cfg(1, 0, 0, OUT_PULSE_LO, 2);
    cmd(ACT_LOAD_ARM, 2);
    pulses(0, 2);
    check_all();
    pulses(0, 2);
    check_all();
    cfg(2, 1, k_rec | k_rl, OUT_TOGGLE, 1);
    bus(1, ra(2, OFS_HOLD), 3);
    m_hd[2] = 3;
    cmd(ACT_LOAD_ARM, 4);
    pulses(1, 4);
    check_all();
    cfg(3, 3, k_up | k_bcd | k_rec, OUT_HIGHZ, 'h9998);
    cmd(ACT_LOAD, 8);
    pulses(3, 1);
    check_all();
    cmd(ACT_ARM, 8);
    pulses(3, 3);
    check_all();
    // counter one parked at its end value opens the gate of counter two
    cfg(0, 5, k_up, OUT_LOW, 'hffff);
    cfg(1, 2, 1 << M_EDGE | 3 << M_GATE_LSB | k_rec, OUT_LOW, 9);
    cmd(ACT_LOAD_ARM, 3);
    pulses(2, 2);
    check_all();
    cmd(ACT_DISARM, 1);
    pulses(2, 2);
    check_all();
    for (int a = 0; a < 8; a += 7) cmd(mmec_action_type'(a), 'h1f);
    check_all();
    test_done();
  end
endmodule : tb_multi_mode_event_counter
bind mmec_top mmec_asserts u_chk (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .cnt_out);
